//--- common/pats_map.svh
// register offsets, field positions, reset values and encodings for pats
`ifndef PATS_MAP_SVH
`define PATS_MAP_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define PATS_OFF_CTRL 12'h000
`define PATS_OFF_STE 12'h004
`define PATS_OFF_STATUS 12'h008
`define PATS_OFF_COUNT 12'h00c
// ************************************************************
// field positions
// ************************************************************
`define PATS_CTRL_CHK_BIT 0
`define PATS_CTRL_NS_SUP_BIT 1
`define PATS_CTRL_ATTR_SUP_BIT 2
`define PATS_CTRL_REALM_BIT 3
`define PATS_CTRL_FWB_BIT 4
`define PATS_STE_MODE_LO 0
`define PATS_STE_CFG_LO 4
`define PATS_STE_VALID_BIT 8
// ************************************************************
// reset values and encodings
// ************************************************************
`define PATS_CTRL_RST 32'h0000_0000
`define PATS_STE_RST 32'h0000_0000
`define PATS_MODE_FULL 2'h1
`define PATS_MODE_SPLIT 2'h2
`define PATS_CFG_NESTED 3'h7
`define PATS_ATTR_FIXED 8'hff
`define PATS_SH_FIXED 2'h3
`define PATS_ATTR_NC 8'h44
`define PATS_SH_OUTER 2'h2
`endif

//--- common/pats_pkg.sv
// types shared by the pats block
package pats_pkg;
  typedef enum logic [1:0] {
    pats_kind_untr,
    pats_kind_treq,
    pats_kind_tran
  } pats_kind_t;
  typedef enum logic [1:0] {
    pats_route_out,
    pats_route_s2,
    pats_route_fault
  } pats_route_t;
endpackage

//--- design/pats_attr.sv
// pcie and ats attribute handling stage with apb registers
//
// Summary of operation
// - no_snoop turns a final normal cacheable attribute into outer shareable non-cached
// - no_snoop leaves any device memory attribute untouched
// - downgrade applies only after the forced writeback stage 2 result
// - every translation completion returns its no_snoop field as zero
// - split mode, check enabled, nested config: completion returns intermediate address
// - split completion holds stage 1 intermediate address, not nested physical address
// - split completion attribute combines with stage 2 to the nested result
// - flag update may occur at request walk or later translated access
// - granted permissions combine stage 1 and stage 2 against the request
// - returned size never exceeds the smaller of stage 1 and stage 2 sizes
// - mode full: translated access goes to output as physical, untranslated
// - mode full: output attribute is encoded one if supported, else fixed
// - mode split: translated address goes through stage 2, which may fault
// - mode split: encoded or fixed attribute feeds stage 2 for combination
// - with check enabled each translated access is checked against its config
// - realm implemented: no stashing, completion bits above address size zero
// - no_snoop behaves as if carried through and applied after the unit
// - translated attribute derivation is independent of the later downgrade
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pats_map.svh"
module pats_attr #(
  parameter int AW = 48,
  parameter int PAS = 44
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // incoming transaction
  input wire logic in_valid,
  input wire pats_pkg::pats_kind_t in_kind,
  input wire logic [AW-1:0] in_addr,
  input wire logic [7:0] in_attr,
  input wire logic in_no_snoop,
  // translation result for requests
  input wire logic [AW-1:0] s1_addr,
  input wire logic [AW-1:0] nested_addr,
  input wire logic [7:0] s1_attr,
  input wire logic [7:0] comb_attr,
  input wire logic [1:0] s1_perm,
  input wire logic [1:0] s2_perm,
  input wire logic [1:0] req_perm,
  input wire logic [5:0] s1_size,
  input wire logic [5:0] s2_size,
  // stage 2 result for translated access
  input wire logic [7:0] s2_attr,
  input wire logic [1:0] s2_sh,
  input wire logic s2_fault,
  // downstream transaction
  output logic out_valid,
  output logic [AW-1:0] out_addr,
  output logic [7:0] out_attr,
  output logic [1:0] out_sh,
  output pats_pkg::pats_route_t out_route,
  // translation completion
  output logic cpl_valid,
  output logic [AW-1:0] cpl_addr,
  output logic [7:0] cpl_attr,
  output logic [1:0] cpl_perm,
  output logic [5:0] cpl_size,
  output logic cpl_n
);
  import pats_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] ste_reg;
  logic [15:0] viol_reg;
  logic [15:0] fault_reg;
  logic [AW-1:0] addr_mask;
  logic chk;
  logic ns_sup;
  logic attr_sup;
  logic realm;
  logic fwb;
  logic [1:0] mode;
  logic [2:0] cfg;
  logic ste_ok;

  // ************************************************************
  // field decode
  // ************************************************************
  assign chk = ctrl_reg[`PATS_CTRL_CHK_BIT];
  assign ns_sup = ctrl_reg[`PATS_CTRL_NS_SUP_BIT];
  assign attr_sup = ctrl_reg[`PATS_CTRL_ATTR_SUP_BIT];
  assign realm = ctrl_reg[`PATS_CTRL_REALM_BIT];
  assign fwb = ctrl_reg[`PATS_CTRL_FWB_BIT];
  assign mode = ste_reg[`PATS_STE_MODE_LO +: 2];
  assign cfg = ste_reg[`PATS_STE_CFG_LO +: 3];
  assign ste_ok = ste_reg[`PATS_STE_VALID_BIT];

  // ************************************************************
  // apb decode
  // ************************************************************
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == `PATS_OFF_CTRL;
  wire hit_ste = paddr == `PATS_OFF_STE;
  wire hit_stat = paddr == `PATS_OFF_STATUS;
  wire hit_cnt = paddr == `PATS_OFF_COUNT;
  wire hit_any = hit_ctrl || hit_ste || hit_stat || hit_cnt;
  wire rd_setup = setup && !pwrite;
  wire err_setup = setup && !hit_any;
  wire [31:0] stat_word = {27'h0, fwb, realm, attr_sup, ns_sup, chk};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
                       hit_ste ? ste_reg :
                       hit_stat ? stat_word :
                       hit_cnt ? {fault_reg, viol_reg} : 32'h0000_0000;
  wire [31:0] rd_data = rd_setup ? rd_mux : 32'h0000_0000;
  wire [31:0] ctrl_wdata = {27'h0, pwdata[4:0]};
  wire [31:0] ste_wdata = {23'h0, pwdata[8:0]};

  // ************************************************************
  // register write, lands at the access edge
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PATS_CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_reg <= ctrl_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ste_reg <= `PATS_STE_RST;
    end else if (wr && hit_ste) begin
      ste_reg <= ste_wdata;
    end
  end

  // ************************************************************
  // apb answer, one cycle after setup
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= err_setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_data;
    end
  end

  // ************************************************************
  // translated access routing
  // ************************************************************
  // software keeps split mode legal only with checks enabled
  wire is_tran = in_kind == pats_kind_tran;
  wire is_treq = in_kind == pats_kind_treq;
  wire split_ok = mode == `PATS_MODE_SPLIT && chk;
  wire tr_checked = !chk || ste_ok;
  wire tr_full = tr_checked && mode == `PATS_MODE_FULL;
  wire tr_split = tr_checked && split_ok && !s2_fault;
  wire tr_fault = !tr_full && !tr_split;
  // encoded attribute only when supported, independent of no_snoop
  wire [7:0] tr_in_attr = attr_sup ? in_attr : `PATS_ATTR_FIXED;
  wire [7:0] s2_out_attr = fwb ? s2_attr : (tr_in_attr & s2_attr);
  wire [7:0] untr_attr = fwb ? s2_attr : (`PATS_ATTR_FIXED & s2_attr);

  // ************************************************************
  // route select
  // ************************************************************
  logic [7:0] pre_attr;
  logic [1:0] pre_sh;
  pats_route_t pre_route;
  always_comb begin
    pre_attr = untr_attr;
    pre_sh = s2_sh;
    pre_route = pats_route_s2;
    if (is_tran) begin
      if (tr_full) begin
        pre_attr = tr_in_attr;
        pre_sh = `PATS_SH_FIXED;
        pre_route = pats_route_out;
      end else if (tr_split) begin
        pre_attr = s2_out_attr;
        pre_route = pats_route_s2;
      end else begin
        pre_route = pats_route_fault;
      end
    end
  end

  // ************************************************************
  // no_snoop downgrade at the output, after forced writeback
  // ************************************************************
  // device types have zero outer nibble; those pass unchanged
  wire is_device = pre_attr[7:4] == 4'h0;
  wire is_cached = !is_device && pre_attr != `PATS_ATTR_NC;
  wire ns_flag = ns_sup && in_no_snoop;
  wire do_down = ns_flag && is_cached;
  wire [7:0] fin_attr = do_down ? `PATS_ATTR_NC : pre_attr;
  wire [1:0] fin_sh = do_down ? `PATS_SH_OUTER : pre_sh;

  // ************************************************************
  // translation completion
  // ************************************************************
  wire split_cpl = split_ok && cfg == `PATS_CFG_NESTED;
  wire [AW-1:0] raw_cpl = split_cpl ? s1_addr : nested_addr;
  wire [7:0] cpl_a = split_cpl ? s1_attr : comb_attr;
  wire [5:0] min_size = (s1_size < s2_size) ? s1_size : s2_size;
  wire [1:0] perm = s1_perm & s2_perm & req_perm;

  // ************************************************************
  // completion address mask
  // ************************************************************
  always_comb begin
    addr_mask = '1;
    if (realm) begin
      addr_mask = ({AW{1'b1}} >> (AW - PAS));
    end
  end
  wire [AW-1:0] cpl_addr_masked = raw_cpl & addr_mask;
  wire [7:0] cpl_attr_sel = attr_sup ? cpl_a : 8'h00;

  // ************************************************************
  // output flops
  // ************************************************************
  wire go_out = in_valid && !is_treq;
  wire go_cpl = in_valid && is_treq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= go_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_addr <= '0;
    end else begin
      out_addr <= in_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_attr <= 8'h00;
      out_sh <= 2'h0;
    end else begin
      out_attr <= fin_attr;
      out_sh <= fin_sh;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_route <= pats_route_out;
    end else begin
      out_route <= pre_route;
    end
  end

  // ************************************************************
  // completion flops
  // ************************************************************
  // flag updates happen in the external walker at either point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_valid <= 1'b0;
    end else begin
      cpl_valid <= go_cpl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_addr <= '0;
    end else begin
      cpl_addr <= cpl_addr_masked;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_attr <= 8'h00;
      cpl_n <= 1'b0;
    end else begin
      cpl_attr <= cpl_attr_sel;
      cpl_n <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpl_perm <= 2'h0;
      cpl_size <= 6'h00;
    end else begin
      cpl_perm <= perm;
      cpl_size <= min_size;
    end
  end

  // ************************************************************
  // status counters
  // ************************************************************
  wire viol_hit = go_out && is_tran && tr_fault;
  wire s2_hit = go_out && s2_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_reg <= 16'h0000;
    end else if (viol_hit) begin
      viol_reg <= viol_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 16'h0000;
    end else if (s2_hit) begin
      fault_reg <= fault_reg + 16'h0001;
    end
  end
endmodule // pats_attr

//--- verif/pats_attr_asserts.sv
// checker for the pats attribute stage ports
`timescale 1ns/1ps
module pats_attr_asserts
  import pats_pkg::*;
#(
  parameter int AW = 48,
  parameter int PAS = 44
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // transactions
  input wire logic in_valid,
  input wire pats_pkg::pats_kind_t in_kind,
  input wire logic [AW-1:0] in_addr,
  input wire logic [1:0] s1_perm,
  input wire logic [1:0] s2_perm,
  input wire logic [1:0] req_perm,
  input wire logic [5:0] s1_size,
  input wire logic [5:0] s2_size,
  input wire logic out_valid,
  input wire logic [AW-1:0] out_addr,
  input wire pats_pkg::pats_route_t out_route,
  input wire logic cpl_valid,
  input wire logic [1:0] cpl_perm,
  input wire logic [5:0] cpl_size,
  input wire logic cpl_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb answer missing");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_cpl_n_zero: assert property (cpl_valid |-> !cpl_n)
    else $error("completion n set");
  a_cpl_follows: assert property (
    in_valid && in_kind == pats_kind_treq |=> cpl_valid)
    else $error("completion missing");
  a_out_follows: assert property (
    in_valid && in_kind != pats_kind_treq |=> out_valid)
    else $error("output missing");
  a_out_cause: assert property (
    out_valid || cpl_valid |-> $past(in_valid))
    else $error("output without input");
  a_size_bound: assert property (cpl_valid |->
    cpl_size <= $past(s1_size) && cpl_size <= $past(s2_size))
    else $error("size too large");
  a_perm_comb: assert property (cpl_valid |-> (cpl_perm &
    ~($past(s1_perm) & $past(s2_perm) & $past(req_perm))) == 2'h0)
    else $error("permission too wide");
  a_full_direct: assert property (out_valid &&
    out_route == pats_route_out && $past(in_kind) == pats_kind_tran
    |-> out_addr == $past(in_addr))
    else $error("direct address changed");
  c_split: cover property (out_valid && out_route == pats_route_s2);
  c_fault: cover property (out_valid && out_route == pats_route_fault);
  c_cpl: cover property (cpl_valid);
endmodule // pats_attr_asserts

bind pats_attr pats_attr_asserts #(.AW(AW), .PAS(PAS)) i_pats_attr_asserts (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .in_valid, .in_kind,
  .in_addr, .s1_perm, .s2_perm, .req_perm, .s1_size, .s2_size, .out_valid,
  .out_addr, .out_route, .cpl_valid, .cpl_perm, .cpl_size, .cpl_n);

//--- verif/pats_rc_model.sv
// root complex model presenting transactions to the pats block
`timescale 1ns/1ps
`include "pats_map.svh"
module pats_rc_model (
  // request from the bench
  input wire logic req,
  input wire pats_pkg::pats_kind_t req_kind,
  input wire logic [47:0] req_addr,
  input wire logic [7:0] req_attr,
  input wire logic req_ns,
  // transaction toward the block
  output logic in_valid,
  output pats_pkg::pats_kind_t in_kind,
  output logic [47:0] in_addr,
  output logic [7:0] in_attr,
  output logic in_no_snoop
);
  import pats_pkg::*;
  logic untr;
  assign untr = req_kind == pats_kind_untr;
  assign in_valid = req;
  assign in_kind = req_kind;
  // idle lines show the inverse of the last value
  assign in_addr = req ? req_addr : ~req_addr;
  // untranslated gets the fixed attribute, device encodings pass as given
  assign in_attr = untr ? `PATS_ATTR_FIXED :
    (req ? req_attr : ~req_attr);
  assign in_no_snoop = req & req_ns;
endmodule // pats_rc_model

//--- verif/tb.sv
// self-checking bench for the pats attribute stage
`timescale 1ns/1ps
`include "pats_map.svh"
module tb;
  import pats_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic req = 0, req_ns = 0, s2_fault = 0, err;
  logic pready, pslverr, in_valid, in_no_snoop, out_valid, cpl_valid, cpl_n;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  pats_kind_t req_kind = pats_kind_untr, in_kind;
  pats_route_t out_route;
  logic [47:0] req_addr = 48'h0, in_addr, out_addr, cpl_addr;
  logic [47:0] s1_addr = 48'hfff0_1234_5000, nested_addr = 48'h0abc_d000;
  logic [7:0] req_attr = 8'h0, s1_attr = 8'hbf, comb_attr = 8'hb7;
  logic [7:0] s2_attr = 8'hf7, in_attr, out_attr, cpl_attr;
  logic [1:0] s1_perm = 2'h3, s2_perm = 2'h1, req_perm = 2'h3, s2_sh = 2'h3;
  logic [1:0] out_sh, cpl_perm;
  logic [5:0] s1_size = 6'h15, s2_size = 6'h0c, cpl_size;
  int n_errors = 0, check_count = 0, cyc = 0;

  pats_attr i_pats_attr (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_kind, .in_addr,
    .in_attr, .in_no_snoop, .s1_addr, .nested_addr, .s1_attr, .comb_attr,
    .s1_perm, .s2_perm, .req_perm, .s1_size, .s2_size, .s2_attr, .s2_sh,
    .s2_fault, .out_valid, .out_addr, .out_attr, .out_sh, .out_route,
    .cpl_valid, .cpl_addr, .cpl_attr, .cpl_perm, .cpl_size, .cpl_n);
  pats_rc_model i_pats_rc_model (.req, .req_kind, .req_addr, .req_attr,
    .req_ns, .in_valid, .in_kind, .in_addr, .in_attr, .in_no_snoop);

  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(logic [31:0] c, logic [31:0] s);
    apb(1'b1, `PATS_OFF_CTRL, c);
    apb(1'b1, `PATS_OFF_STE, s);
    apb(1'b0, `PATS_OFF_STATUS, 32'h0);
    chk("status", rd, c);
  endtask
  task automatic xact(pats_kind_t k, logic [47:0] a, logic [7:0] at,
                      logic ns, logic f);
    @(posedge pclk);
    req <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_attr <= at;
    req_ns <= ns;
    s2_fault <= f;
    @(posedge pclk);
    req <= 1'b0;
    s2_fault <= 1'b0;
    #1;
  endtask

  task automatic t_regs();
    apb(1'b0, `PATS_OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, `PATS_CTRL_RST);
    apb(1'b0, `PATS_OFF_STE, 32'h0);
    chk("ste reset", rd, `PATS_STE_RST);
    apb(1'b1, 12'h010, 32'h1);
    chk("unmapped write", err, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", {err, rd}, 33'h1_0000_0000);
    xact(pats_kind_untr, 48'h1000, 8'h00, 1'b0, 1'b0);
    chk("untr out", out_valid, 1'b1);
  endtask
  task automatic t_full();
    cfg(32'h7, 32'h171);
    xact(pats_kind_tran, 48'h0abc_def0_1000, 8'h4f, 1'b0, 1'b0);
    chk("full route", out_route, pats_route_out);
    chk("full addr", out_addr, 48'h0abc_def0_1000);
    chk("full attr", out_attr, 8'h4f);
    xact(pats_kind_tran, 48'h2000, 8'hff, 1'b1, 1'b0);
    chk("ns attr", out_attr, `PATS_ATTR_NC);
    chk("ns sh", out_sh, `PATS_SH_OUTER);
    xact(pats_kind_tran, 48'h3000, 8'h04, 1'b1, 1'b0);
    chk("ns device", out_attr, 8'h04);
    cfg(32'h3, 32'h171);
    xact(pats_kind_tran, 48'h4000, 8'h4f, 1'b0, 1'b0);
    chk("fixed attr", out_attr, `PATS_ATTR_FIXED);
  endtask
  task automatic t_split();
    cfg(32'h7, 32'h172);
    xact(pats_kind_treq, 48'h5000, 8'h00, 1'b0, 1'b0);
    chk("cpl valid", cpl_valid, 1'b1);
    chk("cpl addr", cpl_addr, 48'hfff0_1234_5000);
    chk("cpl n", cpl_n, 1'b0);
    chk("cpl perm", cpl_perm, 2'h1);
    chk("cpl size", cpl_size, 6'h0c);
    chk("cpl attr", cpl_attr & s2_attr, comb_attr & s2_attr);
    xact(pats_kind_treq, 48'h5000, 8'h00, 1'b1, 1'b0);
    chk("cpl attr ns", cpl_attr & s2_attr, comb_attr & s2_attr);
    xact(pats_kind_tran, 48'h6000, 8'hbf, 1'b0, 1'b0);
    chk("split route", out_route, pats_route_s2);
    chk("split attr", out_attr, 8'hb7);
    xact(pats_kind_tran, 48'h6000, 8'hbf, 1'b0, 1'b1);
    chk("split fault", out_route, pats_route_fault);
    cfg(32'h17, 32'h172);
    xact(pats_kind_tran, 48'h7000, 8'hff, 1'b1, 1'b0);
    chk("fwb ns", out_attr, `PATS_ATTR_NC);
    cfg(32'h7, 32'h072);
    xact(pats_kind_tran, 48'h8000, 8'hff, 1'b0, 1'b0);
    chk("ste check", out_route, pats_route_fault);
    cfg(32'hf, 32'h172);
    xact(pats_kind_treq, 48'h9000, 8'h00, 1'b0, 1'b0);
    chk("realm addr", cpl_addr, 48'h0ff0_1234_5000);
    apb(1'b0, `PATS_OFF_COUNT, 32'h0);
    chk("counts", rd, 32'h0001_0002);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_full();
    t_split();
    test_done();
  end
endmodule // tb
